/* File: peak_current_table.sv */
`timescale 1ns/10ps
// Peak current amplitude lookup in mA
module peak_current_table (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  code,
    output logic      [10:0] milliamp
);

    logic [10:0] milliamp_d;

    always_comb begin
        case (code)
            5'h00: milliamp_d = 11'd33;
            5'h01: milliamp_d = 11'd64;
            5'h02: milliamp_d = 11'd95;
            5'h03: milliamp_d = 11'd104;
            5'h04: milliamp_d = 11'd115;
            5'h05: milliamp_d = 11'd126;
            5'h06: milliamp_d = 11'd138;
            5'h07: milliamp_d = 11'd153;
            5'h08: milliamp_d = 11'd166;
            5'h09: milliamp_d = 11'd190;
            5'h0A: milliamp_d = 11'd205;
            5'h0B: milliamp_d = 11'd230;
            5'h0C: milliamp_d = 11'd250;
            5'h0D: milliamp_d = 11'd275;
            5'h0E: milliamp_d = 11'd300;
            5'h0F: milliamp_d = 11'd325;
            5'h10: milliamp_d = 11'd365;
            5'h11: milliamp_d = 11'd400;
            5'h12: milliamp_d = 11'd440;
            5'h13: milliamp_d = 11'd485;
            5'h14: milliamp_d = 11'd530;
            5'h15: milliamp_d = 11'd585;
            5'h16: milliamp_d = 11'd630;
            5'h17: milliamp_d = 11'd750;
            5'h18: milliamp_d = 11'd825;
            5'h19: milliamp_d = 11'd895;
            5'h1A: milliamp_d = 11'd975;
            5'h1B: milliamp_d = 11'd1065;
            5'h1C: milliamp_d = 11'd1155;
            5'h1D: milliamp_d = 11'd1245;
            5'h1E: milliamp_d = 11'd1365;
            default: milliamp_d = 11'd1480;
        endcase
    end

    // Registered amplitude
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            milliamp <= 11'd0;
        end else begin
            milliamp <= milliamp_d;
        end
    end

endmodule

/* File: status_master_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Master side of the status read path
module status_master_model (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output logic            cs_high,
    output logic            rd_done,
    output logic      [7:0] rd_addr,
    output logic            wden_clear
);
    // Bus idle at time zero
    initial begin
        cs_high    = 1'b1;
        rd_done    = 1'b0;
        rd_addr    = 8'h00;
        wden_clear = 1'b0;
    end

    // Select, take the byte, mark read done, then deselect
    // select raised after read
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk) #1;
        cs_high = 1'b0;
        rd_addr = addr;
        @(posedge clk) #1;
        data    = rd_data;
        rd_done = 1'b1;
        @(posedge clk) #1;
        rd_done = 1'b0;
        cs_high = 1'b1;
    endtask

    // Hold the bus busy or idle
    task automatic set_select(input logic idle);
        @(posedge clk) #1;
        cs_high = idle;
    endtask

    // Zero written to watchdog enable, one cycle
    task automatic clear_watchdog();
        @(posedge clk) #1;
        wden_clear = 1'b1;
        @(posedge clk) #1;
        wden_clear = 1'b0;
    endtask

    function automatic logic warm_boot(input logic [7:0] general);
        return general[stepper_status_pkg::WDOG_POS];
    endfunction
endmodule

/* File: stepper_status_pkg.sv */
package stepper_status_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_GENERAL = 8'h04;
    localparam logic [7:0] ADDR_OVC_X   = 8'h05;
    localparam logic [7:0] ADDR_OVC_Y   = 8'h06;
    localparam logic [7:0] ADDR_STEP    = 8'h07;

    // ==========================================================
    // Field positions
    localparam int PARITY_POS  = 7;
    localparam int THERM_W_POS = 6;
    localparam int PUMP_POS    = 5;
    localparam int WDOG_POS    = 4;
    localparam int OPEN_X_POS  = 3;
    localparam int OPEN_Y_POS  = 2;
    localparam int OVC_LSB     = 3;
    localparam int SHUTDOWN_POS = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Bits that may ever be set, per register
    localparam logic [7:0] MASK_GENERAL = 8'hFC;
    localparam logic [7:0] MASK_OVC_X   = 8'hF8;
    localparam logic [7:0] MASK_OVC_Y   = 8'hFC;
    localparam logic [7:0] MASK_STEP    = 8'hFF;

endpackage

/* File: stepper_status_regs.sv */
`timescale 1ns/10ps
// Status register bank of the stepper driver
module stepper_status_regs (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // Chip select is high (bus idle)
    input  wire logic        CS_HIGH,
    // Completed read of a register, one cycle
    input  wire logic        RD_DONE,
    input  wire logic [7:0]  RD_ADDR,
    // Zero written to watchdog enable, one cycle
    input  wire logic        WDEN_CLEAR,
    // Watchdog not cleared in time, one cycle
    input  wire logic        WDOG_TIMEOUT,
    // Live detector levels
    input  wire logic        THERM_WARN,
    input  wire logic        THERM_SHUT,
    input  wire logic        PUMP_LOW,
    input  wire logic        OPEN_X,
    input  wire logic        OPEN_Y,
    input  wire logic [3:0]  OVC_X,
    input  wire logic [3:0]  OVC_Y,
    input  wire logic [6:0]  STEP_POS,
    input  wire logic [4:0]  PEAK_CURRENT_CODE,
    output logic      [7:0]  STATUS_GENERAL,
    output logic      [7:0]  STATUS_OVC_X,
    output logic      [7:0]  STATUS_OVC_Y,
    output logic      [7:0]  STATUS_STEP,
    output logic      [7:0]  RD_DATA,
    output logic             ERR_O,
    output logic             ERR_OE,
    output logic      [10:0] PEAK_CURRENT_MA
);

    // ==========================================================
    // Reset release
    logic       rst_meta_q;
    logic       rst_n;

    // Two-stage release of the reset
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ==========================================================
    // Watchdog event flag
    logic       wdog_q;
    logic       wdog_d;

    always_comb begin
        wdog_d = wdog_q;
        if (WDEN_CLEAR) begin
            wdog_d = 1'b0;
        end
        if (WDOG_TIMEOUT) begin
            wdog_d = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wdog_q <= 1'b0;
        end else begin
            wdog_q <= wdog_d;
        end
    end

    // ==========================================================
    // Pending clear of latched registers
    logic       clr_x_q;
    logic       clr_x_d;
    logic       clr_y_q;
    logic       clr_y_d;

    // read while selected marks clear, applied at next idle cycle
    always_comb begin
        clr_x_d = clr_x_q;
        clr_y_d = clr_y_q;
        if (CS_HIGH) begin
            clr_x_d = 1'b0;
            clr_y_d = 1'b0;
        end else begin
            // Idle reads clear at once, so no second clear is left pending
            if (RD_DONE && RD_ADDR == stepper_status_pkg::ADDR_OVC_X) begin
                clr_x_d = 1'b1;
            end
            if (RD_DONE && RD_ADDR == stepper_status_pkg::ADDR_OVC_Y) begin
                clr_y_d = 1'b1;
            end
        end
    end

    // Pending clear registers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            clr_x_q <= 1'b0;
            clr_y_q <= 1'b0;
        end else begin
            clr_x_q <= clr_x_d;
            clr_y_q <= clr_y_d;
        end
    end

    // ==========================================================
    // Status registers
    logic [7:0] gen_q;
    logic [7:0] gen_d;
    logic [7:0] ovx_q;
    logic [7:0] ovx_d;
    logic [7:0] ovy_q;
    logic [7:0] ovy_d;
    logic [7:0] stp_q;
    logic [7:0] stp_d;
    logic       err_q;
    logic       err_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic       clr_x_now;
    logic       clr_y_now;
    logic [3:0] ovx_flags;
    logic [4:0] ovy_flags;

    // hardware sources load the images, reads of X and Y clear their latched flags
    always_comb begin
        gen_d     = gen_q;
        ovx_d     = ovx_q;
        ovy_d     = ovy_q;
        stp_d     = stp_q;
        err_d     = err_q;
        clr_x_now = clr_x_q || (RD_DONE && RD_ADDR == stepper_status_pkg::ADDR_OVC_X);
        clr_y_now = clr_y_q || (RD_DONE && RD_ADDR == stepper_status_pkg::ADDR_OVC_Y);
        ovx_flags = ovx_q[6:3];
        ovy_flags = ovy_q[6:2];
        // update only while chip select high
        if (CS_HIGH) begin
            gen_d = stepper_status_pkg::STATUS_RESET;
            gen_d[stepper_status_pkg::THERM_W_POS] = THERM_WARN;
            gen_d[stepper_status_pkg::PUMP_POS]    = PUMP_LOW;
            gen_d[stepper_status_pkg::WDOG_POS]    = wdog_q;
            gen_d[stepper_status_pkg::OPEN_X_POS]  = OPEN_X;
            gen_d[stepper_status_pkg::OPEN_Y_POS]  = OPEN_Y;
            // latched X overcurrent, new event beats clear
            for (int i = 0; i < 4; i++) begin
                ovx_flags[i] = (ovx_q[stepper_status_pkg::OVC_LSB + i] && !clr_x_now) || OVC_X[i];
            end
            for (int i = 0; i < 4; i++) begin
                ovy_flags[i + 1] = (ovy_q[stepper_status_pkg::OVC_LSB + i] && !clr_y_now) || OVC_Y[i];
            end
            ovy_flags[0] = (ovy_q[stepper_status_pkg::SHUTDOWN_POS] && !clr_y_now) || THERM_SHUT;
            ovx_d = {1'b0, ovx_flags, 3'b000};
            ovy_d = {1'b0, ovy_flags, 2'b00};
            stp_d = {1'b0, STEP_POS};
            // parity bit over bits 6 to 0
            gen_d[stepper_status_pkg::PARITY_POS] = ^gen_d[6:0];
            ovx_d[stepper_status_pkg::PARITY_POS] = ^ovx_d[6:0];
            ovy_d[stepper_status_pkg::PARITY_POS] = ^ovy_d[6:0];
            stp_d[stepper_status_pkg::PARITY_POS] = ^stp_d[6:0];
            err_d = (|ovx_flags) || (|ovy_flags);
        end
    end

    // Read data selection, unmapped reads zero
    always_comb begin
        case (RD_ADDR)
            stepper_status_pkg::ADDR_GENERAL: rd_d = gen_q;
            stepper_status_pkg::ADDR_OVC_X:   rd_d = ovx_q;
            stepper_status_pkg::ADDR_OVC_Y:   rd_d = ovy_q;
            stepper_status_pkg::ADDR_STEP:    rd_d = stp_q;
            default:                          rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            gen_q <= stepper_status_pkg::STATUS_RESET;
            ovx_q <= stepper_status_pkg::STATUS_RESET;
            ovy_q <= stepper_status_pkg::STATUS_RESET;
            stp_q <= stepper_status_pkg::STATUS_RESET;
            err_q <= 1'b0;
            rd_q  <= 8'h00;
        end else begin
            gen_q <= gen_d;
            ovx_q <= ovx_d;
            ovy_q <= ovy_d;
            stp_q <= stp_d;
            err_q <= err_d;
            rd_q  <= rd_d;
        end
    end

    // ==========================================================
    // Outputs
    assign STATUS_GENERAL = gen_q;
    assign STATUS_OVC_X   = ovx_q;
    assign STATUS_OVC_Y   = ovy_q;
    assign STATUS_STEP    = stp_q;
    assign RD_DATA        = rd_q;
    // Open drain error pin, pulled low while error
    assign ERR_O          = 1'b0;
    assign ERR_OE         = err_q;

    // Peak current amplitude
    peak_current_table u_table (
        .clk      (CLK),
        .rst_n    (rst_n),
        .code     (PEAK_CURRENT_CODE),
        .milliamp (PEAK_CURRENT_MA)
    );

    // ==========================================================
    // Checks
    a_parity_valid: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (^gen_q == 1'b0) && (^ovx_q == 1'b0) && (^ovy_q == 1'b0) && (^stp_q == 1'b0))
        else $error("Status parity bit wrong");

    a_unused_zero: assert property (
        @(posedge CLK) disable iff (!rst_n)
        ((gen_q & ~stepper_status_pkg::MASK_GENERAL) == 8'h00)
        && ((ovx_q & ~stepper_status_pkg::MASK_OVC_X) == 8'h00)
        && ((ovy_q & ~stepper_status_pkg::MASK_OVC_Y) == 8'h00))
        else $error("Unused status bit set");

    a_frozen_cs_low: assert property (
        @(posedge CLK) disable iff (!rst_n)
        !CS_HIGH |=> $stable(gen_q) && $stable(ovx_q) && $stable(ovy_q) && $stable(stp_q) && $stable(err_q))
        else $error("Status changed while selected");

    a_wdog_set: assert property (
        @(posedge CLK) disable iff (!rst_n)
        WDOG_TIMEOUT ##1 (!WDEN_CLEAR && CS_HIGH)[*1] |=> gen_q[stepper_status_pkg::WDOG_POS])
        else $error("Watchdog flag not shown");

    a_wdog_hold: assert property (
        @(posedge CLK) disable iff (!rst_n)
        wdog_q && !WDEN_CLEAR |=> wdog_q)
        else $error("Watchdog flag lost without enable write");

    a_ovc_latch: assert property (
        @(posedge CLK) disable iff (!rst_n)
        CS_HIGH && OVC_X[3] |=> ovx_q[6])
        else $error("Overcurrent flag not latched");

    a_read_clears: assert property (
        @(posedge CLK) disable iff (!rst_n)
        (RD_DONE && RD_ADDR == stepper_status_pkg::ADDR_OVC_Y && !THERM_SHUT && OVC_Y == 4'h0)
        ##1 (CS_HIGH && !THERM_SHUT && OVC_Y == 4'h0)
        |=> ovy_q == 8'h00)
        else $error("Read did not clear latched register");

    a_error_pin: assert property (
        @(posedge CLK) disable iff (!rst_n)
        CS_HIGH |=> ERR_OE == ((|ovx_q[6:3]) || (|ovy_q[6:2])))
        else $error("Error output disagrees with flags");

    a_step_follow: assert property (
        @(posedge CLK) disable iff (!rst_n)
        CS_HIGH |=> stp_q[6:0] == $past(STEP_POS))
        else $error("Step position not tracked");

    a_pump_follow: assert property (
        @(posedge CLK) disable iff (!rst_n)
        CS_HIGH |=> gen_q[stepper_status_pkg::PUMP_POS] == $past(PUMP_LOW))
        else $error("Pump flag not tracked");

    a_current_range: assert property (
        @(posedge CLK) disable iff (!rst_n)
        PEAK_CURRENT_CODE == 5'h1F |=> PEAK_CURRENT_MA == 11'd1480)
        else $error("Top current code wrong");

endmodule

/* File: tb_stepper_driver_status_regs.sv */
`timescale 1ns/10ps
// ==========================================================
// Bench for the status register bank
module tb_stepper_driver_status_regs;
    logic        clk, rstn, wdog_timeout, therm_warn, therm_shut, pump_low, open_x, open_y;
    logic [3:0]  ovc_x, ovc_y;
    logic [6:0]  step_pos;
    logic [4:0]  peak_code;
    logic        cs_high, rd_done, wden_clear, err_o, err_oe;
    logic [7:0]  rd_addr, rd_data, st_gen, st_x, st_y, st_step, d;
    logic [10:0] peak_ma;
    wire         err_pin_n;
    int          n_fail, checks_done;
    int          ma_tab[32] = '{33, 64, 95, 104, 115, 126, 138, 153, 166, 190, 205, 230, 250, 275, 300, 325,
                                365, 400, 440, 485, 530, 585, 630, 750, 825, 895, 975, 1065, 1155, 1245, 1365, 1480};

    // Open-drain pin with pull-up
    assign err_pin_n = err_oe ? err_o : 1'b1;

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    stepper_status_regs i_dut (
        .CLK(clk), .RSTN(rstn), .CS_HIGH(cs_high), .RD_DONE(rd_done), .RD_ADDR(rd_addr),
        .WDEN_CLEAR(wden_clear), .WDOG_TIMEOUT(wdog_timeout), .THERM_WARN(therm_warn),
        .THERM_SHUT(therm_shut), .PUMP_LOW(pump_low), .OPEN_X(open_x), .OPEN_Y(open_y),
        .OVC_X(ovc_x), .OVC_Y(ovc_y), .STEP_POS(step_pos), .PEAK_CURRENT_CODE(peak_code),
        .STATUS_GENERAL(st_gen), .STATUS_OVC_X(st_x), .STATUS_OVC_Y(st_y), .STATUS_STEP(st_step),
        .RD_DATA(rd_data), .ERR_O(err_o), .ERR_OE(err_oe), .PEAK_CURRENT_MA(peak_ma)
    );

    status_master_model i_master (
        .clk(clk), .rd_data(rd_data), .cs_high(cs_high), .rd_done(rd_done),
        .rd_addr(rd_addr), .wden_clear(wden_clear)
    );

    // ==========================================================
    // Shared helpers
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] with_parity(input logic [6:0] v);
        return {^v, v};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // All registers and pin clear out of reset
    task automatic t_reset();
        check("err pin", 11'h001, {10'h000, err_pin_n});
        for (int a = 4; a < 8; a++) begin
            i_master.read_reg(8'(a), d);
            check("reset read", 11'h000, {3'b000, d});
        end
    endtask

    // Live flags of the general register, one at a time
    task automatic t_general();
        logic [6:0] bits[4];
        bits = '{7'h40, 7'h20, 7'h08, 7'h04};
        for (int i = 0; i < 4; i++) begin
            {therm_warn, pump_low, open_x, open_y} = 4'h8 >> i;
            step(2);
            check("general", {3'b000, with_parity(bits[i])}, {3'b000, st_gen});
            {therm_warn, pump_low, open_x, open_y} = 4'h0;
            step(2);
            check("general off", 11'h000, {3'b000, st_gen});
        end
    endtask

    // Latched overcurrent and shutdown, cleared by read
    task automatic t_latched();
        logic [7:0] ex, ey;
        for (int i = 0; i < 9; i++) begin
            ovc_x      = (i < 4) ? 4'h8 >> i : 4'h0;
            ovc_y      = (i >= 4 && i < 8) ? 4'h8 >> (i - 4) : 4'h0;
            therm_shut = (i == 8);
            ex         = with_parity({ovc_x, 3'b000});
            ey         = with_parity({ovc_y, therm_shut, 2'b00});
            step(1);
            {ovc_x, ovc_y, therm_shut} = 9'h000;
            step(2);
            check("ovc x held", {3'b000, ex}, {3'b000, st_x});
            check("ovc y held", {3'b000, ey}, {3'b000, st_y});
            check("err pin low", 11'h000, {10'h000, err_pin_n});
            i_master.read_reg((i < 4) ? 8'h05 : 8'h06, d);
            check("read latched", {3'b000, (i < 4) ? ex : ey}, {3'b000, d});
            step(2);
            check("x cleared", 11'h000, {3'b000, st_x});
            check("y cleared", 11'h000, {3'b000, st_y});
            check("err pin released", 11'h001, {10'h000, err_pin_n});
        end
    endtask

    // Step position and freeze while the bus is busy
    task automatic t_freeze();
        step_pos = 7'h2A;
        step(2);
        check("step", {3'b000, with_parity(7'h2A)}, {3'b000, st_step});
        i_master.set_select(1'b0);
        step_pos = 7'h55;
        ovc_x    = 4'h1;
        step(3);
        check("step frozen", {3'b000, with_parity(7'h2A)}, {3'b000, st_step});
        check("x frozen", 11'h000, {3'b000, st_x});
        check("err frozen", 11'h001, {10'h000, err_pin_n});
        i_master.set_select(1'b1);
        step(2);
        ovc_x = 4'h0;
        check("step live", {3'b000, with_parity(7'h55)}, {3'b000, st_step});
        check("x late", {3'b000, with_parity(7'h08)}, {3'b000, st_x});
        i_master.read_reg(8'h05, d);
        i_master.read_reg(8'h00, d);
        check("unmapped", 11'h000, {3'b000, d});
        step(2);
        check("x cleared", 11'h000, {3'b000, st_x});
    endtask

    // Watchdog flag survives reads, cleared by enable write
    task automatic t_watchdog();
        wdog_timeout = 1'b1;
        step(1);
        wdog_timeout = 1'b0;
        step(2);
        check("wdog set", {3'b000, with_parity(7'h10)}, {3'b000, st_gen});
        check("warm boot", 11'h001, {10'h000, i_master.warm_boot(st_gen)});
        i_master.read_reg(8'h04, d);
        step(2);
        check("wdog kept", {3'b000, with_parity(7'h10)}, {3'b000, st_gen});
        i_master.clear_watchdog();
        step(2);
        check("wdog clear", 11'h000, {3'b000, st_gen});
    endtask

    // Every peak current code, then a lowered code with its overcurrent
    task automatic t_current();
        for (int c = 0; c < 32; c++) begin
            peak_code = 5'(c);
            step(2);
            check("peak mA", 11'(ma_tab[c]), peak_ma);
        end
        // lowered code, master reads and clears flags
        peak_code = 5'h0F;
        ovc_y     = 4'h2;
        step(1);
        ovc_y = 4'h0;
        i_master.read_reg(8'h06, d);
        check("ovc after lower", {3'b000, with_parity(7'h10)}, {3'b000, d});
        step(2);
        check("ovc handled", 11'h000, {3'b000, st_y});
        check("peak lowered", 11'(ma_tab[15]), peak_ma);
    endtask

    // ==========================================================
    // Main sequence, every wait is a fixed count
    initial begin
        {clk, rstn, wdog_timeout, therm_warn, therm_shut, pump_low, open_x, open_y} = 8'h00;
        {ovc_x, ovc_y, step_pos, peak_code} = 20'h0_0000;
        n_fail      = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        step(3);
        t_reset();
        t_general();
        t_latched();
        t_freeze();
        t_watchdog();
        t_current();
        test_done();
    end
endmodule
